// ==== rtl/bch_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bch_defs.svh"
module bch_dev #(
	parameter int NREG = `BCH_NREG,
	parameter int OTP_CYC = `BCH_OTP_CYCLES,
	parameter int PROBE_CYC = `BCH_PROBE_CYCLES,
	parameter int AUTO_CYC = `BCH_AUTO_CYCLES
) (
	input wire logic CLK,
	input wire logic NRST,
	bch_link_if.dev LINK,
	input wire logic ADDR_SEL,
	input wire logic BOOT_SEL,
	input wire logic MEM_PRESENT,
	input wire logic RECORDS_VALID,
	input wire logic [1:0] RECORD_ACTION,
	output var bch_pkg::bch_boot_t BOOT_MODE,
	output var logic STREAMING,
	output var logic CONFIG_DONE
);
	import bch_pkg::*;
	localparam int IW = $clog2(NREG);

	logic [7:0] s1_ff;
	logic [7:0] s2_ff;
	logic scl_p_ff;
	logic sda_p_ff;
	logic scl_s;
	logic sda_s;
	logic addr_sel_s;
	logic boot_sel_s;
	logic mem_s;
	logic rec_s;
	logic [1:0] act_s;
	logic start_ev;
	logic stop_ev;
	logic scl_rise;
	logic scl_fall;

	bch_boot_t boot_ff;
	logic [15:0] bcnt_ff;
	logic cmd_go_ff;

	bch_slv_t st_ff;
	logic [3:0] cnt_ff;
	logic [1:0] idx_ff;
	logic rw_ff;
	logic half_ff;
	logic [15:0] ptr_ff;
	logic [7:0] shr_ff;
	logic [7:0] tmp_ff;
	logic acki_ff;
	logic [15:0] regs_ff [NREG];
	logic [7:0] own_addr;
	logic [15:0] rd_word;
	logic [7:0] txb;

	// Pins change on another clock, so every one passes two flops first.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			// Clock and data start at their idle high level, so no false edge follows reset.
			s1_ff <= 8'hc0;
			s2_ff <= 8'hc0;
			scl_p_ff <= 1'b1;
			sda_p_ff <= 1'b1;
		end else begin
			s1_ff <= {LINK.scl, LINK.sda, ADDR_SEL, BOOT_SEL, MEM_PRESENT, RECORDS_VALID,
				RECORD_ACTION};
			s2_ff <= s1_ff;
			scl_p_ff <= s2_ff[7];
			sda_p_ff <= s2_ff[6];
		end
	end

	assign scl_s = s2_ff[7];
	assign sda_s = s2_ff[6];
	assign addr_sel_s = s2_ff[5];
	assign boot_sel_s = s2_ff[4];
	assign mem_s = s2_ff[3];
	assign rec_s = s2_ff[2];
	assign act_s = s2_ff[1:0];
	assign start_ev = scl_s & scl_p_ff & sda_p_ff & ~sda_s;
	assign stop_ev = scl_s & scl_p_ff & ~sda_p_ff & sda_s;
	assign scl_rise = scl_s & ~scl_p_ff;
	assign scl_fall = ~scl_s & scl_p_ff;
	assign own_addr = addr_sel_s ? `BCH_ADDR_HI : `BCH_ADDR_LO;

	// Boot sequence, restarted by every reset.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			boot_ff <= B_OTP;
			bcnt_ff <= 16'h0000;
		end else begin
			bcnt_ff <= bcnt_ff + 16'h0001;
			case (boot_ff)
				B_OTP: begin
					if (bcnt_ff == 16'(OTP_CYC - 1)) begin
						boot_ff <= B_DETECT;
						bcnt_ff <= 16'h0000;
					end
				end
				B_DETECT: begin
					if (bcnt_ff == 16'(PROBE_CYC - 1)) begin
						bcnt_ff <= 16'h0000;
						if (mem_s) begin
							boot_ff <= B_FLASH;
						end else if (boot_sel_s) begin
							boot_ff <= B_AUTO;
						end else begin
							boot_ff <= B_HOST;
						end
					end
				end
				B_FLASH: begin
					if (bcnt_ff == 16'(PROBE_CYC - 1)) begin
						bcnt_ff <= 16'h0000;
						boot_ff <= rec_s ? B_RECORDS : B_AUTO;
					end
				end
				B_RECORDS: begin
					if (bcnt_ff == 16'(PROBE_CYC - 1)) begin
						bcnt_ff <= 16'h0000;
						case (act_s)
							`BCH_ACT_AUTO: boot_ff <= B_AUTO;
							`BCH_ACT_STREAM: boot_ff <= B_STREAM;
							default: boot_ff <= B_HOST;
						endcase
					end
				end
				B_HOST: begin
					bcnt_ff <= 16'h0000;
					if (cmd_go_ff) begin
						boot_ff <= B_STREAM;
					end
				end
				B_AUTO: begin
					if (bcnt_ff == 16'(AUTO_CYC - 1)) begin
						bcnt_ff <= 16'h0000;
						boot_ff <= B_STREAM;
					end
				end
				B_STREAM: begin
					bcnt_ff <= 16'h0000;
				end
				default: begin
					boot_ff <= B_OTP;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			BOOT_MODE <= B_OTP;
			STREAMING <= 1'b0;
			CONFIG_DONE <= 1'b0;
		end else begin
			BOOT_MODE <= boot_ff;
			STREAMING <= (boot_ff == B_STREAM);
			CONFIG_DONE <= (boot_ff == B_STREAM) || (boot_ff == B_HOST);
		end
	end

	// The status word is read-only and mirrors the boot mode.
	assign rd_word = (ptr_ff[IW-1:0] == IW'(`BCH_REG_STAT)) ? {13'h0000, boot_ff} :
		regs_ff[ptr_ff[IW-1:0]];
	assign txb = half_ff ? rd_word[7:0] : rd_word[15:8];

	// Two-wire slave. The data line only changes while the clock is low.
	always_ff @(posedge CLK) begin
		cmd_go_ff <= 1'b0;
		if (!NRST) begin
			st_ff <= SL_IDLE;
			cnt_ff <= 4'h0;
			idx_ff <= 2'h0;
			rw_ff <= 1'b0;
			half_ff <= 1'b0;
			ptr_ff <= 16'h0000;
			shr_ff <= 8'h00;
			tmp_ff <= 8'h00;
			acki_ff <= 1'b0;
			LINK.dev_sda_o <= 1'b0;
			LINK.dev_sda_oe <= 1'b0;
			for (int i = 0; i < NREG; i++) begin
				regs_ff[i] <= 16'h0000;
			end
		end else if (start_ev) begin
			st_ff <= SL_RX;
			cnt_ff <= 4'h0;
			idx_ff <= 2'h0;
			LINK.dev_sda_oe <= 1'b0;
		end else if (stop_ev) begin
			st_ff <= SL_IDLE;
			LINK.dev_sda_oe <= 1'b0;
		end else begin
			case (st_ff)
				SL_RX: begin
					if (scl_rise) begin
						shr_ff <= {shr_ff[6:0], sda_s};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == 4'h8) begin
						LINK.dev_sda_oe <= 1'b1;
						st_ff <= SL_ACKO;
						case (idx_ff)
							2'h0: begin
								if (shr_ff[7:1] != own_addr[7:1]) begin
									LINK.dev_sda_oe <= 1'b0;
									st_ff <= SL_IDLE;
								end
								rw_ff <= shr_ff[0];
							end
							2'h1: ptr_ff[15:8] <= shr_ff;
							2'h2: begin
								ptr_ff[7:0] <= shr_ff;
								half_ff <= 1'b0;
							end
							default: begin
								if (!half_ff) begin
									tmp_ff <= shr_ff;
									half_ff <= 1'b1;
								end else begin
									if (ptr_ff[IW-1:0] != IW'(`BCH_REG_STAT)) begin
										regs_ff[ptr_ff[IW-1:0]] <= {tmp_ff, shr_ff};
									end
									cmd_go_ff <= (ptr_ff[IW-1:0] == IW'(`BCH_REG_CMD)) &&
										shr_ff[`BCH_CMD_STREAM_BIT];
									ptr_ff <= ptr_ff + 16'h0001;
									half_ff <= 1'b0;
								end
							end
						endcase
					end
				end
				SL_ACKO: begin
					if (scl_fall) begin
						cnt_ff <= 4'h0;
						acki_ff <= 1'b0;
						if (rw_ff) begin
							// Pointer and half-word carry over, so a bare read continues.
							st_ff <= SL_TX;
							LINK.dev_sda_oe <= ~txb[7];
						end else begin
							st_ff <= SL_RX;
							LINK.dev_sda_oe <= 1'b0;
							idx_ff <= (idx_ff == 2'h3) ? 2'h3 : idx_ff + 2'h1;
						end
					end
				end
				SL_TX: begin
					if (scl_rise && cnt_ff == 4'h9) begin
						if (sda_s) begin
							st_ff <= SL_IDLE;
						end else begin
							acki_ff <= 1'b1;
							half_ff <= ~half_ff;
							if (half_ff) begin
								ptr_ff <= ptr_ff + 16'h0001;
							end
						end
					end else if (scl_rise) begin
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && acki_ff) begin
						acki_ff <= 1'b0;
						cnt_ff <= 4'h0;
						LINK.dev_sda_oe <= ~txb[7];
					end else if (scl_fall && cnt_ff == 4'h8) begin
						LINK.dev_sda_oe <= 1'b0;
						cnt_ff <= 4'h9;
					end else if (scl_fall && cnt_ff < 4'h8) begin
						LINK.dev_sda_oe <= ~txb[~cnt_ff[2:0]];
					end
				end
				default: begin
					LINK.dev_sda_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== include/bch_defs.svh ====
`ifndef BCH_DEFS_SVH
`define BCH_DEFS_SVH
`define BCH_ADDR_LO 8'h90
`define BCH_ADDR_HI 8'hBA
`define BCH_OTP_CYCLES 16
`define BCH_PROBE_CYCLES 8
`define BCH_AUTO_CYCLES 32
`define BCH_SCL_QTR 8
`define BCH_NREG 16
`define BCH_REG_CMD 16'h0000
`define BCH_REG_STAT 16'h0001
`define BCH_CMD_STREAM_BIT 0
`define BCH_ACT_AUTO 2'h1
`define BCH_ACT_STREAM 2'h2
`endif

// ==== include/bch_pkg.sv ====
package bch_pkg;
	typedef enum logic [2:0] {
		B_OTP = 3'b000,
		B_DETECT = 3'b001,
		B_FLASH = 3'b010,
		B_RECORDS = 3'b011,
		B_HOST = 3'b100,
		B_AUTO = 3'b101,
		B_STREAM = 3'b110
	} bch_boot_t;
	typedef enum logic [1:0] {
		SL_IDLE = 2'b00,
		SL_RX = 2'b01,
		SL_ACKO = 2'b10,
		SL_TX = 2'b11
	} bch_slv_t;
	typedef enum logic [3:0] {
		H_IDLE = 4'b0000,
		H_START = 4'b0001,
		H_DEVW = 4'b0010,
		H_AHI = 4'b0011,
		H_ALO = 4'b0100,
		H_WDAT = 4'b0101,
		H_RSTART = 4'b0110,
		H_DEVR = 4'b0111,
		H_RDAT = 4'b1000,
		H_STOP = 4'b1001
	} bch_hst_t;
endpackage

// ==== include/bch_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface bch_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// Open-drain wires with pull-ups: any enabled low driver pulls the line down.
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
		output host_sda_oe, input scl, input sda);
	modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// ==== rtl/bch_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bch_defs.svh"
module bch_host #(
	parameter int QTR = `BCH_SCL_QTR
) (
	input wire logic CLK,
	input wire logic NRST,
	bch_link_if.host LINK,
	input wire logic GO,
	input wire logic RW,
	input wire logic CUR_LOC,
	input wire logic DEV_SEL,
	input wire logic [15:0] REG_ADDR,
	input wire logic [7:0] NBYTES,
	input wire logic [7:0] WR_BYTE,
	output var logic BUSY,
	output var logic DONE,
	output var logic WR_TAKE,
	output var logic [7:0] RD_BYTE,
	output var logic RD_VALID,
	output var logic ACK_ERR
);
	import bch_pkg::*;

	bch_hst_t st_ff;
	logic [15:0] div_ff;
	logic [1:0] ph_ff;
	logic [3:0] bit_ff;
	logic [7:0] rem_ff;
	logic [7:0] shr_ff;
	logic [15:0] adr_ff;
	logic rw_ff;
	logic dsel_ff;
	logic s1_ff;
	logic s2_ff;
	logic tick;
	logic last_bit;
	logic [7:0] dev_byte;
	logic [7:0] tx_byte;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
		end else begin
			s1_ff <= LINK.sda;
			s2_ff <= s1_ff;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST || st_ff == H_IDLE || tick) begin
			div_ff <= 16'h0000;
		end else begin
			div_ff <= div_ff + 16'h0001;
		end
	end

	assign tick = (div_ff == 16'(QTR - 1));
	assign last_bit = (ph_ff == 2'h3) && (bit_ff == 4'h8);
	assign dev_byte = dsel_ff ? `BCH_ADDR_HI : `BCH_ADDR_LO;
	always_comb begin
		case (st_ff)
			H_DEVW: tx_byte = dev_byte;
			H_AHI: tx_byte = adr_ff[15:8];
			H_ALO: tx_byte = adr_ff[7:0];
			H_DEVR: tx_byte = dev_byte | 8'h01;
			default: tx_byte = WR_BYTE;
		endcase
	end

	// The host makes the serial clock from its own clock by a quarter-period divider.
	always_ff @(posedge CLK) begin
		DONE <= 1'b0;
		WR_TAKE <= 1'b0;
		RD_VALID <= 1'b0;
		if (!NRST) begin
			st_ff <= H_IDLE;
			ph_ff <= 2'h0;
			bit_ff <= 4'h0;
			rem_ff <= 8'h00;
			shr_ff <= 8'h00;
			adr_ff <= 16'h0000;
			rw_ff <= 1'b0;
			dsel_ff <= 1'b0;
			BUSY <= 1'b0;
			RD_BYTE <= 8'h00;
			ACK_ERR <= 1'b0;
			LINK.host_scl_o <= 1'b0;
			LINK.host_scl_oe <= 1'b0;
			LINK.host_sda_o <= 1'b0;
			LINK.host_sda_oe <= 1'b0;
		end else if (st_ff == H_IDLE) begin
			if (GO) begin
				st_ff <= H_START;
				ph_ff <= 2'h0;
				bit_ff <= 4'h0;
				rem_ff <= NBYTES;
				adr_ff <= REG_ADDR;
				rw_ff <= RW;
				dsel_ff <= DEV_SEL;
				BUSY <= 1'b1;
				ACK_ERR <= 1'b0;
			end
		end else if (tick) begin
			ph_ff <= ph_ff + 2'h1;
			case (st_ff)
				H_START, H_RSTART: begin
					case (ph_ff)
						2'h0: LINK.host_sda_oe <= 1'b0;
						2'h1: LINK.host_scl_oe <= 1'b0;
						2'h2: LINK.host_sda_oe <= 1'b1;
						default: begin
							LINK.host_scl_oe <= 1'b1;
							st_ff <= (st_ff == H_RSTART || (rw_ff && CUR_LOC)) ? H_DEVR :
								H_DEVW;
						end
					endcase
				end
				H_STOP: begin
					case (ph_ff)
						2'h0: LINK.host_sda_oe <= 1'b1;
						2'h1: LINK.host_scl_oe <= 1'b0;
						2'h2: LINK.host_sda_oe <= 1'b0;
						default: begin
							st_ff <= H_IDLE;
							BUSY <= 1'b0;
							DONE <= 1'b1;
						end
					endcase
				end
				default: begin
					case (ph_ff)
						2'h0: begin
							if (st_ff == H_RDAT) begin
								// Ack every byte but the last, which gets a nack.
								LINK.host_sda_oe <= bit_ff[3] && (rem_ff != 8'h01);
							end else begin
								LINK.host_sda_oe <= !bit_ff[3] && !tx_byte[~bit_ff[2:0]];
							end
						end
						2'h1: LINK.host_scl_oe <= 1'b0;
						2'h2: begin
							if (bit_ff[3] && st_ff != H_RDAT && s2_ff) begin
								ACK_ERR <= 1'b1;
							end
							if (!bit_ff[3]) begin
								shr_ff <= {shr_ff[6:0], s2_ff};
							end
						end
						default: begin
							LINK.host_scl_oe <= 1'b1;
							bit_ff <= bit_ff + 4'h1;
						end
					endcase
					if (last_bit) begin
						bit_ff <= 4'h0;
						case (st_ff)
							H_DEVW: st_ff <= H_AHI;
							H_AHI: st_ff <= H_ALO;
							H_ALO: st_ff <= rw_ff ? H_RSTART : (rem_ff == 8'h00 ? H_STOP : H_WDAT);
							H_WDAT: begin
								WR_TAKE <= 1'b1;
								rem_ff <= rem_ff - 8'h01;
								st_ff <= (rem_ff == 8'h01) ? H_STOP : H_WDAT;
							end
							H_DEVR: st_ff <= H_RDAT;
							H_RDAT: begin
								RD_BYTE <= shr_ff;
								RD_VALID <= 1'b1;
								rem_ff <= rem_ff - 8'h01;
								st_ff <= (rem_ff == 8'h01) ? H_STOP : H_RDAT;
							end
							default: st_ff <= H_STOP;
						endcase
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== tb/bch_link_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module bch_link_props (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic [7:0] idle_ff;
	logic [7:0] nxt_idle;
	// Saturates so a long idle bus never wraps back out of the quiet window.
	assign nxt_idle = !(scl && sda) ? 8'h00 : (idle_ff == 8'hff) ? idle_ff : idle_ff + 8'h01;
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			idle_ff <= 8'h00;
		end else begin
			idle_ff <= nxt_idle;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	chk_reset_lines_free: assert property (
		$rose(NRST) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
		else $error("link driven at reset release");
	chk_host_open_drain: assert property (
		!(host_scl_oe && host_scl_o) && !(host_sda_oe && host_sda_o))
		else $error("host drives a line high");
	chk_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drives data high");
	chk_dev_data_stable: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device data moved while clock high");
	chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	chk_scl_low_span: assert property ($fell(scl) |-> !scl [*8] ##[1:40] scl)
		else $error("clock low phase out of range");
	chk_stop_dev_free: assert property (
		scl && $past(scl) && $rose(sda) |=> !dev_sda_oe [*4])
		else $error("device drives data after stop");
	chk_idle_bus_quiet: assert property (
		idle_ff >= 8'h28 |-> !dev_sda_oe && !host_scl_oe)
		else $error("line driven on idle bus");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import bch_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic go = 1'b0, rw = 1'b0, cur = 1'b0, dsel = 1'b0, asel = 1'b0;
	logic bsel = 1'b0, mem = 1'b0, rv = 1'b0;
	logic [1:0] act = 2'h0;
	logic [15:0] radr = 16'h0000;
	logic [7:0] nb = 8'h00;
	logic [7:0] wb = 8'h00;
	logic busy, done, take, rdv, aerr, strm, cdone;
	logic [7:0] rb;
	bch_boot_t mode, last;
	logic [23:0] seq;
	int n_fail = 0;
	int n_tests = 0;
	logic [7:0] q[$];
	// Case bits are {memory, records, boot select, action}.
	logic [4:0] cfg[7] = '{5'h00, 5'h04, 5'h10, 5'h19, 5'h1a, 5'h1b, 5'h18};
	logic [23:0] exp_seq[7] = '{24'h00_0014, 24'h00_0156, 24'h00_1256, 24'h01_2356,
		24'h00_1236, 24'h00_1234, 24'h00_1234};
	bch_link_if lnk ();
	always #4 clk = ~clk;
	bch_dev bch_dev_i (.CLK(clk), .NRST(nrst), .LINK(lnk), .ADDR_SEL(asel), .BOOT_SEL(bsel),
		.MEM_PRESENT(mem), .RECORDS_VALID(rv), .RECORD_ACTION(act), .BOOT_MODE(mode),
		.STREAMING(strm), .CONFIG_DONE(cdone));
	bch_host bch_host_i (.CLK(clk), .NRST(nrst), .LINK(lnk), .GO(go), .RW(rw), .CUR_LOC(cur),
		.DEV_SEL(dsel), .REG_ADDR(radr), .NBYTES(nb), .WR_BYTE(wb), .BUSY(busy), .DONE(done),
		.WR_TAKE(take), .RD_BYTE(rb), .RD_VALID(rdv), .ACK_ERR(aerr));
	bch_link_props bch_link_props_i (.CLK(clk), .NRST(nrst), .host_scl_o(lnk.host_scl_o),
		.host_scl_oe(lnk.host_scl_oe), .host_sda_o(lnk.host_sda_o),
		.host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
		.dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic put(input logic [15:0] w);
		q.push_back(w[15:8]);
		q.push_back(w[7:0]);
	endtask
	function automatic logic [23:0] word(input int i);
		return {8'h00, q[2*i], q[2*i+1]};
	endfunction
	// Write bytes are taken from q; read bytes replace q in bus order.
	task automatic xfer(input logic r, input logic c, input logic d, input logic [15:0] a,
		input logic [7:0] n);
		int k;
		k = 0;
		if (r) begin
			q.delete();
		end
		@(negedge clk);
		rw = r;
		cur = c;
		dsel = d;
		radr = a;
		nb = n;
		wb = (q.size() > 0) ? q[0] : 8'h00;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		while (done !== 1'b1) begin
			if (take === 1'b1 && !r) begin
				void'(q.pop_front());
				wb = (q.size() > 0) ? q[0] : 8'h00;
			end
			if (rdv === 1'b1 && r) begin
				q.push_back(rb);
			end
			k++;
			if (k > 20000) begin
				n_fail++;
				$display("[ERR] %0t transfer never finished", $time);
				print_verdict();
			end
			@(negedge clk);
		end
		chk(24'(busy), 24'h00_0000);
		chk(24'(q.size()), r ? 24'(n) : 24'h00_0000);
	endtask
	initial begin
		for (int i = 0; i < 7; i++) begin
			@(negedge clk);
			{mem, rv, bsel, act} = cfg[i];
			nrst = 1'b0;
			repeat (4) @(negedge clk);
			nrst = 1'b1;
			seq = 24'h00_0000;
			last = B_OTP;
			repeat (200) begin
				@(negedge clk);
				if (mode !== last) begin
					seq = {seq[19:0], 1'b0, mode};
					last = mode;
				end
			end
			chk(seq, exp_seq[i]);
			chk(24'({strm, cdone}), 24'({exp_seq[i][2:0] == 3'h6,
				exp_seq[i][2:0] == 3'h6 || exp_seq[i][2:0] == 3'h4}));
			$display("boot case %0d finished", i);
		end
		q.delete();
		put(16'h1234);
		put(16'h5678);
		put(16'h9abc);
		xfer(1'b0, 1'b0, 1'b0, 16'h0002, 8'h06);
		chk(24'(aerr), 24'h00_0000);
		xfer(1'b1, 1'b0, 1'b0, 16'h0002, 8'h06);
		chk(word(0), 24'h00_1234);
		chk(word(1), 24'h00_5678);
		chk(word(2), 24'h00_9abc);
		q.delete();
		xfer(1'b0, 1'b0, 1'b0, 16'h0003, 8'h00);
		xfer(1'b1, 1'b1, 1'b0, 16'h0000, 8'h04);
		chk(word(0), 24'h00_5678);
		chk(word(1), 24'h00_9abc);
		q.delete();
		put(16'hffff);
		xfer(1'b0, 1'b0, 1'b0, 16'h0001, 8'h02);
		xfer(1'b1, 1'b0, 1'b0, 16'h0001, 8'h02);
		chk(word(0), 24'h00_0004);
		$display("register access tests finished");
		asel = 1'b1;
		q.delete();
		put(16'h0001);
		xfer(1'b0, 1'b0, 1'b0, 16'h0000, 8'h02);
		chk(24'(aerr), 24'h00_0001);
		chk(24'(mode), 24'(B_HOST));
		xfer(1'b1, 1'b0, 1'b1, 16'h0002, 8'h02);
		chk(word(0), 24'h00_1234);
		q.delete();
		put(16'h0001);
		xfer(1'b0, 1'b0, 1'b1, 16'h0000, 8'h02);
		repeat (8) @(negedge clk);
		chk(24'(aerr), 24'h00_0000);
		chk(24'({strm, mode}), 24'({1'b1, B_STREAM}));
		$display("address select and streaming tests finished");
		print_verdict();
	end
endmodule
`default_nettype wire
